/* rtl/swu_ec_regs.sv */
// What this block does
// (R1) Standby power-up resets reg one bits 7 to 3, route bit to one; warm clears bit0
// (R2) Route bit set by default disables kbd data routing
// (R3) Bit five selects software event clear mode
// (R4) Lock freezes base address and itself
// (R5) Valid sets on high byte write, W1C
// (R6) Bit two shows bus reset active
// (R7) Bit one shows main power on
// (R8) Host reset bit drives keyboard reset active
// (R9) Reg two cleared by standby or bus reset
// (R10) Supply-off change flag, write one clears
// (R11) Button-mode change flag, write one clears
// (R12) Sleep request flags mirror host, W1C
// (R13) Awake flag sets on all-zero host request
// (R14) Reg three reset only by battery power-up, hold bit to one
// (R15) RTC alarm flag sets on alarm, W1C
// (R16) Power-fail bit forces reset and A20 low
// (R17) Hold bit keeps keyboard reset during bus cycles
// (R18) Hold bit writes ignored while locked
// (R19) Base low byte, read/write, resets zero
// (R20) Base high byte, read/write
// (R21) Host sets sleep request bits to ask sleep
// (R22) W1C touches ones only; reserved reads zero
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module swu_ec_regs
    import swu_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic [SWU_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [SWU_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  standbyPorRst,
    input  wire logic                  warmRst,
    input  wire logic                  watchdogRst,
    input  wire logic                  batteryPorRst,
    input  wire logic                  standbyRstBusy,
    input  wire logic                  busCycleActive,
    input  wire logic                  bus_reset_in_n,
    input  wire logic                  mainPowerOn,
    input  wire logic                  busPowerDown_n,
    input  wire logic                  rtcAlarm,
    input  wire logic                  supply_off_bit,
    input  wire logic                  button_mode_bit,
    input  wire logic                  hostAcpiWrite,
    input  wire logic [4:0]            hostAcpiData,
    input  wire logic [1:0]            kbd_output_data_reg,
    input  wire logic                  gateA20Default,
    output logic                       keyboard_reset_out_n,
    output logic                       gate_a20_out,
    output logic                       sw_event_clear_mode,
    output logic [15:0]                hostCfgBase,
    output logic                       hostCfgValid
);

    // Register index decode, shared by read and write paths
    function automatic logic [7:0] regIndex(input logic [SWU_ADDR_W-1:0] a);
        regIndex = a[SWU_WORD_SHIFT +: 8];
    endfunction

    function automatic logic isMapped(input logic [7:0] idx);
        isMapped = (idx == SWU_IDX_CTRL_ONE) || (idx == SWU_IDX_CTRL_TWO)
                || (idx == SWU_IDX_CTRL_THREE) || (idx == SWU_IDX_BASE_LOW)
                || (idx == SWU_IDX_BASE_HIGH);
    endfunction

    // Pin synchronisers; first stage feeds only the second
    logic [SWU_SYNC_W-1:0] syncOne;
    logic [SWU_SYNC_W-1:0] syncTwo;
    logic                  rtcPrev;
    logic                  busRstActive;
    logic                  powerDownActive;
    logic                  rtcRise;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            syncOne <= SWU_SYNC_IDLE;
            syncTwo <= SWU_SYNC_IDLE;
            rtcPrev <= 1'b0;
        end
        else
        begin
            syncOne <= {rtcAlarm, busPowerDown_n, mainPowerOn, bus_reset_in_n};
            syncTwo <= syncOne;
            rtcPrev <= syncTwo[SWU_SYNC_RTC];
        end
    end

    assign busRstActive    = !syncTwo[SWU_SYNC_BUS_RST];
    assign powerDownActive = !syncTwo[SWU_SYNC_PD];
    assign rtcRise         = syncTwo[SWU_SYNC_RTC] && !rtcPrev;

    // Bus slave state
    logic                  awHeld;
    logic                  wHeld;
    logic [SWU_ADDR_W-1:0] awAddr;
    logic [31:0]           wData;
    logic [3:0]            wStrb;
    logic                  next_awHeld;
    logic                  next_wHeld;
    logic [SWU_ADDR_W-1:0] next_awAddr;
    logic [31:0]           next_wData;
    logic [3:0]            next_wStrb;
    logic                  next_bvalid;
    logic [1:0]            next_bresp;
    logic                  next_arready;
    logic                  next_rvalid;
    logic [31:0]           next_rdata;
    logic [1:0]            next_rresp;
    logic                  wrFire;
    logic [7:0]            wrIdx;
    logic [7:0]            wrByte;
    logic                  wrLane;

    // Register state
    logic       routeDis;
    logic       clrMode;
    logic       addrLock;
    logic       addrValid;
    logic       hostRst;
    logic [7:0] regTwo;
    logic       rtcFlag;
    logic       pfForce;
    logic       holdRst;
    logic [7:0] baseLow;
    logic [7:0] baseHigh;
    logic       supplyPrev;
    logic       buttonPrev;
    logic       next_routeDis;
    logic       next_clrMode;
    logic       next_addrLock;
    logic       next_addrValid;
    logic       next_hostRst;
    logic [7:0] next_regTwo;
    logic       next_rtcFlag;
    logic       next_pfForce;
    logic       next_holdRst;
    logic [7:0] next_baseLow;
    logic [7:0] next_baseHigh;
    logic       next_kbrstN;
    logic       next_a20;

    // Composed read value of one register; reserved bits read zero
    function automatic logic [7:0] readReg(input logic [7:0] idx);
        readReg = SWU_RST_BYTE;
        unique case (idx)
            SWU_IDX_CTRL_ONE:
            begin
                readReg[SWU_ONE_ROUTE_DIS] = routeDis;
                readReg[SWU_ONE_CLR_MODE]  = clrMode;
                readReg[SWU_ONE_LOCK]      = addrLock;
                readReg[SWU_ONE_VALID]     = addrValid;
                readReg[SWU_ONE_BUS_RST]   = busRstActive;           // [R6]
                readReg[SWU_ONE_MAIN_PWR]  = syncTwo[SWU_SYNC_PWR];  // [R7]
                readReg[SWU_ONE_HOST_RST]  = hostRst;
            end
            SWU_IDX_CTRL_TWO:
                readReg = regTwo;
            SWU_IDX_CTRL_THREE:
            begin
                readReg[SWU_THREE_RTC]  = rtcFlag;
                readReg[SWU_THREE_PF]   = pfForce;
                readReg[SWU_THREE_HOLD] = holdRst;
            end
            SWU_IDX_BASE_LOW:
                readReg = baseLow;
            SWU_IDX_BASE_HIGH:
                readReg = baseHigh;
            default:
                readReg = SWU_RST_BYTE;
        endcase
    endfunction

    assign wrFire = awHeld && wHeld && !s_axi_bvalid;
    assign wrIdx  = regIndex(awAddr);
    assign wrByte = wData[7:0];
    assign wrLane = wrFire && wStrb[0];

    // Address and data are taken independently; the answer waits for both
    always_comb
    begin
        next_awHeld  = awHeld;
        next_wHeld   = wHeld;
        next_awAddr  = awAddr;
        next_wData   = wData;
        next_wStrb   = wStrb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_arready = s_axi_arready;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
        end
        if (wrFire)
        begin
            next_awHeld = 1'b0;
            next_wHeld  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = isMapped(wrIdx) ? SWU_RESP_OKAY : SWU_RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
            next_bvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rdata   = {24'h000000, readReg(regIndex(s_axi_araddr))};
            next_rresp   = isMapped(regIndex(s_axi_araddr)) ? SWU_RESP_OKAY
                                                           : SWU_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
    end

    // Ready is held low while a beat is parked, so one write is open at a time
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= '0;
            wData         <= 32'h00000000;
            wStrb         <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= SWU_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= SWU_RESP_OKAY;
        end
        else
        begin
            awHeld        <= next_awHeld;
            wHeld         <= next_wHeld;
            awAddr        <= next_awAddr;
            wData         <= next_wData;
            wStrb         <= next_wStrb;
            s_axi_awready <= !next_awHeld && !next_bvalid;
            s_axi_wready  <= !next_wHeld && !next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // Register updates: W1C clears, then hardware sets over them, then domain resets last so they win
    always_comb
    begin
        next_routeDis  = routeDis;
        next_clrMode   = clrMode;
        next_addrLock  = addrLock;
        next_addrValid = addrValid;
        next_hostRst   = hostRst;
        next_regTwo    = regTwo;
        next_rtcFlag   = rtcFlag;
        next_pfForce   = pfForce;
        next_holdRst   = holdRst;
        next_baseLow   = baseLow;
        next_baseHigh  = baseHigh;
        if (wrLane && wrIdx == SWU_IDX_CTRL_ONE)
        begin
            next_routeDis = wrByte[SWU_ONE_ROUTE_DIS];                     // [R2]
            next_clrMode  = wrByte[SWU_ONE_CLR_MODE];                      // [R3]
            next_addrLock = addrLock | wrByte[SWU_ONE_LOCK];               // [R4]
            next_hostRst  = wrByte[SWU_ONE_HOST_RST];                      // [R8]
            if (wrByte[SWU_ONE_VALID])
                next_addrValid = 1'b0;                                     // [R5] [R22]
        end
        if (wrLane && wrIdx == SWU_IDX_CTRL_TWO)
            next_regTwo = regTwo & ~wrByte;                                // [R10] [R11] [R12] [R22]
        if (wrLane && wrIdx == SWU_IDX_CTRL_THREE)
        begin
            next_pfForce = wrByte[SWU_THREE_PF];
            if (!addrLock)
                next_holdRst = wrByte[SWU_THREE_HOLD];                     // [R18]
            if (wrByte[SWU_THREE_RTC])
                next_rtcFlag = 1'b0;
        end
        // Lock freezes the base address; writes are quietly dropped
        if (wrLane && !addrLock && wrIdx == SWU_IDX_BASE_LOW)
            next_baseLow = wrByte;                                         // [R4] [R19]
        if (wrLane && !addrLock && wrIdx == SWU_IDX_BASE_HIGH)
            next_baseHigh = wrByte;                                        // [R20]
        // Hardware sets, placed after the clears so they win
        if (wrLane && wrIdx == SWU_IDX_BASE_HIGH)
            next_addrValid = 1'b1;                                         // [R5]
        if (supply_off_bit != supplyPrev)
            next_regTwo[SWU_TWO_SUPPLY_OFF] = 1'b1;                        // [R10]
        if (button_mode_bit != buttonPrev)
            next_regTwo[SWU_TWO_BTN_MODE] = 1'b1;                          // [R11]
        if (hostAcpiWrite)
        begin
            next_regTwo[SWU_TWO_SLEEP_HI:SWU_TWO_SLEEP_LO] =
                next_regTwo[SWU_TWO_SLEEP_HI:SWU_TWO_SLEEP_LO] | hostAcpiData; // [R12] [R21]
            if (hostAcpiData == SWU_SLEEP_NONE)
                next_regTwo[SWU_TWO_AWAKE] = 1'b1;                         // [R13]
        end
        if (rtcRise)
            next_rtcFlag = 1'b1;                                           // [R15]
        // Domain resets, each touching only its own bits
        if (standbyPorRst)
        begin
            next_routeDis  = SWU_RST_ROUTE_DIS;                            // [R1]
            next_clrMode   = 1'b0;
            next_addrValid = 1'b0;
            next_baseLow   = SWU_RST_BYTE;
            next_baseHigh  = SWU_RST_BYTE;
        end
        if (standbyPorRst || watchdogRst)
            next_addrLock = 1'b0;                                          // [R4]
        if (warmRst)
            next_hostRst = 1'b0;                                           // [R1]
        if (standbyPorRst || busRstActive)
            next_regTwo = SWU_RST_BYTE;                                    // [R9]
        if (batteryPorRst)
        begin
            next_rtcFlag = 1'b0;                                           // [R14]
            next_pfForce = 1'b0;
            next_holdRst = SWU_RST_HOLD;
        end
    end

    // Pin drive; power-fail forcing overrides every other source
    always_comb
    begin
        next_kbrstN = 1'b1;
        if (hostRst)
            next_kbrstN = 1'b0;                                            // [R8]
        if (!routeDis && !kbd_output_data_reg[SWU_KDO_RST])
            next_kbrstN = 1'b0;                                            // [R2]
        if (holdRst && standbyRstBusy && busCycleActive)
            next_kbrstN = 1'b0;                                            // [R17]
        next_a20 = routeDis ? gateA20Default : kbd_output_data_reg[SWU_KDO_A20]; // [R2]
        if (pfForce && powerDownActive)
        begin
            next_kbrstN = 1'b0;                                            // [R16]
            next_a20    = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            routeDis             <= SWU_RST_ROUTE_DIS;
            clrMode              <= 1'b0;
            addrLock             <= 1'b0;
            addrValid            <= 1'b0;
            hostRst              <= 1'b0;
            regTwo               <= SWU_RST_BYTE;
            rtcFlag              <= 1'b0;
            pfForce              <= 1'b0;
            holdRst              <= SWU_RST_HOLD;
            baseLow              <= SWU_RST_BYTE;
            baseHigh             <= SWU_RST_BYTE;
            supplyPrev           <= 1'b0;
            buttonPrev           <= 1'b0;
            keyboard_reset_out_n <= 1'b1;
            gate_a20_out         <= 1'b0;
            sw_event_clear_mode  <= 1'b0;
            hostCfgBase          <= 16'h0000;
            hostCfgValid         <= 1'b0;
        end
        else
        begin
            routeDis             <= next_routeDis;
            clrMode              <= next_clrMode;
            addrLock             <= next_addrLock;
            addrValid            <= next_addrValid;
            hostRst              <= next_hostRst;
            regTwo               <= next_regTwo;
            rtcFlag              <= next_rtcFlag;
            pfForce              <= next_pfForce;
            holdRst              <= next_holdRst;
            baseLow              <= next_baseLow;
            baseHigh             <= next_baseHigh;
            supplyPrev           <= supply_off_bit;
            buttonPrev           <= button_mode_bit;
            keyboard_reset_out_n <= next_kbrstN;
            gate_a20_out         <= next_a20;
            sw_event_clear_mode  <= next_clrMode;                          // [R3]
            hostCfgBase          <= {next_baseHigh, next_baseLow};
            hostCfgValid         <= next_addrValid;
        end
    end

    // Checks on the register behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_lock_freezes_base: assert property (addrLock && !standbyPorRst && !watchdogRst
        |=> $stable(baseLow) && $stable(baseHigh) && addrLock)    // [R4]
        else $error("base address changed while locked");
    a_valid_on_high: assert property (wrLane && wrIdx == SWU_IDX_BASE_HIGH && !standbyPorRst
        |=> addrValid && hostCfgValid)                             // [R5]
        else $error("valid flag not set by high byte write");
    a_host_rst_pin: assert property (hostRst |=> !keyboard_reset_out_n)  // [R8]
        else $error("keyboard reset not driven by host reset bit");
    a_two_bus_rst: assert property (busRstActive |=> regTwo == SWU_RST_BYTE)  // [R9]
        else $error("second register not cleared by bus reset");
    a_rtc_sets_flag: assert property (rtcRise && !batteryPorRst |=> rtcFlag)  // [R15]
        else $error("rtc alarm flag not set");
    a_pf_forces_low: assert property (pfForce && powerDownActive
        |=> !keyboard_reset_out_n && !gate_a20_out)               // [R16]
        else $error("power-fail did not force pins low");
    a_hold_locked: assert property (addrLock && !batteryPorRst |=> $stable(holdRst))  // [R18]
        else $error("hold bit changed while locked");
    a_awake_on_zero: assert property (hostAcpiWrite && hostAcpiData == SWU_SLEEP_NONE
        && !standbyPorRst && !busRstActive |=> regTwo[SWU_TWO_AWAKE])  // [R13]
        else $error("awake flag not set");
    a_standby_one: assert property (standbyPorRst && !warmRst && !wrFire
        |=> routeDis && !clrMode && !addrLock && hostRst == $past(hostRst))  // [R1]
        else $error("standby reset mishandled first register");

    c_write_done: cover property (wrFire ##[1:4] (s_axi_bvalid && s_axi_bready));
    c_read_done: cover property (s_axi_rvalid && s_axi_rready);
    c_lock_set: cover property (!addrLock ##1 addrLock);
    c_sleep_req: cover property (hostAcpiWrite ##1 (|regTwo[SWU_TWO_SLEEP_HI:SWU_TWO_SLEEP_LO]));

endmodule // swu_ec_regs

/* include/swu_pkg.sv */
package swu_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [7:0] SWU_IDX_CTRL_ONE   = 8'h00;
    localparam logic [7:0] SWU_IDX_CTRL_TWO   = 8'h02;
    localparam logic [7:0] SWU_IDX_CTRL_THREE = 8'h04;
    localparam logic [7:0] SWU_IDX_BASE_LOW   = 8'h08;
    localparam logic [7:0] SWU_IDX_BASE_HIGH  = 8'h0A;
    localparam int         SWU_ADDR_W         = 12;
    localparam int         SWU_WORD_SHIFT     = 2;

    // First control/status register fields
    localparam int SWU_ONE_ROUTE_DIS = 7;
    localparam int SWU_ONE_CLR_MODE  = 5;
    localparam int SWU_ONE_LOCK      = 4;
    localparam int SWU_ONE_VALID     = 3;
    localparam int SWU_ONE_BUS_RST   = 2;
    localparam int SWU_ONE_MAIN_PWR  = 1;
    localparam int SWU_ONE_HOST_RST  = 0;

    // Second control/status register fields
    localparam int SWU_TWO_SUPPLY_OFF = 7;
    localparam int SWU_TWO_BTN_MODE   = 6;
    localparam int SWU_TWO_SLEEP_HI   = 5;
    localparam int SWU_TWO_SLEEP_LO   = 1;
    localparam int SWU_TWO_AWAKE      = 0;

    // Third control/status register fields
    localparam int SWU_THREE_RTC  = 2;
    localparam int SWU_THREE_PF   = 1;
    localparam int SWU_THREE_HOLD = 0;

    // Keyboard output data bits that feed the routed pins
    localparam int SWU_KDO_RST = 0;
    localparam int SWU_KDO_A20 = 1;

    // Reset values
    localparam logic       SWU_RST_ROUTE_DIS = 1'b1;
    localparam logic       SWU_RST_HOLD      = 1'b1;
    localparam logic [7:0] SWU_RST_BYTE      = 8'h00;
    localparam logic [4:0] SWU_SLEEP_NONE    = 5'h00;

    // AXI responses
    localparam logic [1:0] SWU_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SWU_RESP_SLVERR = 2'h2;

    // Pin synchroniser lanes
    localparam int SWU_SYNC_W       = 4;
    localparam int SWU_SYNC_BUS_RST = 0;
    localparam int SWU_SYNC_PWR     = 1;
    localparam int SWU_SYNC_PD      = 2;
    localparam int SWU_SYNC_RTC     = 3;
    localparam logic [3:0] SWU_SYNC_IDLE = 4'h5;
endpackage

/* testbench/swu_host_model.sv */
`timescale 1ns/1ps
module swu_host_model
(
    input  wire logic       clk,
    input  wire logic       postReq,
    input  wire logic [4:0] reqBits,
    output logic            hostAcpiWrite,
    output logic [4:0]      hostAcpiData
);
    initial {hostAcpiWrite, hostAcpiData} = 6'h0A;
    // Data toggles outside the pulse so a stale request never looks valid
    always @(posedge clk)
    begin
        hostAcpiWrite <= postReq;
        hostAcpiData  <= postReq ? reqBits : ~hostAcpiData;
    end
endmodule // swu_host_model

/* testbench/swu_ec_regs_bench.sv */
`timescale 1ns/1ps
module swu_ec_regs_bench
    import swu_pkg::*;
;
    logic [SWU_ADDR_W-1:0] awAddr = '0, arAddr = '0;
    logic [31:0]           wData = 32'h0, rData;
    logic [1:0]            bResp, rResp, kdo = 2'h0;
    logic [3:0]            domRst = 4'h0;
    logic [4:0]            reqBits = 5'h0, acpiData;
    logic [15:0]           cfgBase;
    logic clk = 1'h0, sysRst = 1'h1, awValid = 1'h0, wValid = 1'h0, bReady = 1'h0;
    logic arValid = 1'h0, rReady = 1'h0, rstBusy = 1'h0, busCycle = 1'h0, busRst_n = 1'h1;
    logic powerDown_n = 1'h1, rtcAlarm = 1'h0, supplyOff = 1'h0, buttonMode = 1'h0;
    logic postReq = 1'h0, acpiWrite, awReady, wReady, bValid, arReady, rValid;
    logic kbdRst_n, gateA20, swClrMode, cfgValid, mainPwr = 1'h1;
    int   badCount = 0, numChecks = 0;

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    swu_host_model swu_host_model_i
    (
        .clk(clk), .postReq(postReq), .reqBits(reqBits), .hostAcpiWrite(acpiWrite),
        .hostAcpiData(acpiData)
    );

    // Domain resets share one vector: bit 0 warm, 1 watchdog, 2 standby, 3 battery
    swu_ec_regs swu_ec_regs_i
    (
        .clk(clk), .sys_rst(sysRst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .standbyPorRst(domRst[2]), .warmRst(domRst[0]), .watchdogRst(domRst[1]),
        .batteryPorRst(domRst[3]), .standbyRstBusy(rstBusy), .busCycleActive(busCycle),
        .bus_reset_in_n(busRst_n), .mainPowerOn(mainPwr), .busPowerDown_n(powerDown_n),
        .rtcAlarm(rtcAlarm), .supply_off_bit(supplyOff), .button_mode_bit(buttonMode),
        .hostAcpiWrite(acpiWrite), .hostAcpiData(acpiData), .kbd_output_data_reg(kdo),
        .gateA20Default(1'h1), .keyboard_reset_out_n(kbdRst_n), .gate_a20_out(gateA20),
        .sw_event_clear_mode(swClrMode), .hostCfgBase(cfgBase), .hostCfgValid(cfgValid)
    );

    task automatic conclude();
        $display("checks %0d, mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            badCount++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask

    // A hung handshake ends the run instead of stalling it
    task automatic guard(input int n);
        if (n > 40)
        begin
            badCount++;
            conclude();
        end
    endtask

    // Address and data are each released at the edge that takes them
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
        int   n = 0;
        logic a = 1'h1, w = 1'h1;
        @(posedge clk);
        awAddr <= SWU_ADDR_W'({idx, 2'h0});
        wData <= {24'h0, d};
        {awValid, wValid, bReady} <= 3'h7;
        while (a || w)
        begin
            @(posedge clk);
            guard(n++);
            if (awReady) a = 1'h0;
            if (wReady) w = 1'h0;
            awValid <= a;
            wValid <= w;
        end
        do
        begin
            @(posedge clk);
            guard(n++);
        end
        while (!bValid);
        bReady <= 1'h0;
        chk(32'(bResp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er = 2'h0);
        int n = 0;
        @(posedge clk);
        arAddr <= SWU_ADDR_W'({idx, 2'h0});
        {arValid, rReady} <= 2'h3;
        do
        begin
            @(posedge clk);
            guard(n++);
        end
        while (!arReady);
        arValid <= 1'h0;
        do
        begin
            @(posedge clk);
            guard(n++);
        end
        while (!rValid);
        rReady <= 1'h0;
        chk(rData, {24'h0, e});
        chk(32'(rResp), 32'(er));
    endtask

    // Pins settle within three edges of an async change
    task automatic pins(input logic k, input logic a);
        repeat (4) @(posedge clk);
        chk(32'({kbdRst_n, gateA20}), 32'({k, a}));
    endtask

    task automatic dom(input logic [3:0] m);
        @(posedge clk);
        domRst <= m;
        @(posedge clk);
        domRst <= 4'h0;
    endtask

    task automatic post(input logic [4:0] b);
        @(posedge clk);
        {postReq, reqBits} <= {1'h1, b};
        @(posedge clk);
        postReq <= 1'h0;
    endtask

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        sysRst <= 1'h0;
        // Live status bits lag two edges behind their pins
        repeat (2) @(posedge clk);
        rd(8'h00, 8'h82);
        rd(8'h04, 8'h01);
        rd(8'h08, 8'h00);
        wr(8'h30, 8'hFF, 2'h2);
        rd(8'h30, 8'h00, 2'h2);
        pins(1'h1, 1'h1);
        wr(8'h00, 8'h20);
        pins(1'h0, 1'h0);
        chk(32'(swClrMode), 32'h1);
        kdo <= 2'h3;
        pins(1'h1, 1'h1);
        wr(8'h00, 8'h01);
        pins(1'h0, 1'h1);
        dom(4'h1);
        rd(8'h00, 8'h02);
        wr(8'h08, 8'h34);
        wr(8'h0A, 8'h12);
        chk({15'h0, cfgValid, cfgBase}, 32'h11234);
        rd(8'h00, 8'h0A);
        wr(8'h00, 8'h18);
        wr(8'h08, 8'h55);
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h00);
        chk({15'h0, cfgValid, cfgBase}, 32'h01234);
        rd(8'h04, 8'h01);
        rd(8'h00, 8'h12);
        dom(4'h2);
        rd(8'h00, 8'h02);
        {supplyOff, buttonMode} <= 2'h3;
        post(5'h1F);
        rd(8'h02, 8'hFE);
        wr(8'h02, 8'h42);
        post(5'h00);
        rd(8'h02, 8'hBD);
        wr(8'h02, 8'hC3);
        rd(8'h02, 8'h3C);
        busRst_n <= 1'h0;
        repeat (4) @(posedge clk);
        rd(8'h00, 8'h06);
        rd(8'h02, 8'h00);
        {busRst_n, rtcAlarm} <= 2'h3;
        repeat (4) @(posedge clk);
        rd(8'h04, 8'h05);
        wr(8'h04, 8'h07);
        rd(8'h04, 8'h03);
        dom(4'h4);
        rd(8'h04, 8'h03);
        rd(8'h00, 8'h82);
        powerDown_n <= 1'h0;
        pins(1'h0, 1'h0);
        {powerDown_n, rstBusy, busCycle} <= 3'h7;
        pins(1'h0, 1'h1);
        dom(4'h8);
        rd(8'h04, 8'h01);
        mainPwr <= 1'h0;
        repeat (4) @(posedge clk);
        rd(8'h00, 8'h80);
        conclude();
    end
endmodule // swu_ec_regs_bench
